// file: hw/skip_subtract_exec.sv
// execution of increment-skip, bit-skip and subtract instructions
// Contract
// - inc-skip writes memory byte plus one into accumulator; memory stays untouched.
// - inc-skip skips the next instruction when the incremented value is zero.
// - a taken skip costs two cycles via an inserted dummy slot.
// - bit-skip skips when the selected memory bit is one, else continues.
// - subtract puts accumulator minus memory byte into accumulator.
// - subtract-into-memory writes accumulator minus memory byte back to memory.
// - subtract-immediate puts accumulator minus immediate into accumulator.
// - subtracts clear carry when negative, set it when zero or positive.
`timescale 1ns/100ps
`default_nettype none
module skip_subtract_exec
   import skip_sub_pkg::*;
(
   input  wire logic                 sys_clk,     // core clock
   input  wire logic                 nrst,        // async reset, active low
   input  wire logic                 op_valid,    // instruction issued this cycle
   input  wire logic [2:0]           op_code,     // op_e encoding
   input  wire logic [7:0]           mem_rdata,   // addressed memory byte
   input  wire logic [7:0]           imm_data,    // immediate operand
   input  wire logic [BIT_SEL_W-1:0] bit_sel,     // bit index for bit-skip
   output logic                      op_ready,    // can take an instruction
   output logic      [7:0]           accumulator, // accumulator
   output logic                      carry_flag,  // carry
   output logic                      aux_carry_flag, // aux carry
   output logic                      zero_flag,   // zero
   output logic                      overflow_flag, // overflow
   output logic                      mem_we,      // memory write strobe
   output logic      [7:0]           mem_wdata,   // memory write data
   output logic                      skip_next,   // next fetched instr is dropped
   output logic                      dummy_slot   // dummy cycle in progress
);
   logic [7:0]  accumulator_ff;
   logic [7:0]  nxt_accumulator;
   logic [3:0]  flags_ff;
   logic [3:0]  nxt_flags;
   logic        mem_we_ff;
   logic [7:0]  mem_wdata_ff;
   logic        skip_ff;
   exec_state_e state_ff;
   exec_state_e nxt_state;

   wire logic       go;
   wire logic       is_inc;
   wire logic       is_bit;
   wire logic       is_sub_acc;
   wire logic       is_sub_mem;
   wire logic       is_sub_imm;
   wire logic       is_sub;
   wire logic [7:0] inc_val;
   wire logic       inc_zero;
   wire logic       bit_set;
   wire logic       take_skip;
   wire logic [7:0] sub_operand;
   wire logic [7:0] sub_diff;
   wire logic [3:0] sub_flags;

   assign op_ready   = (state_ff == ST_IDLE);
   assign go         = op_valid & op_ready;
   assign is_inc     = go & (op_code == OP_INC_SKIP_ACC);
   assign is_bit     = go & (op_code == OP_SKIP_BIT_NZ);
   assign is_sub_acc = go & (op_code == OP_SUB_ACC);
   assign is_sub_mem = go & (op_code == OP_SUB_MEM);
   assign is_sub_imm = go & (op_code == OP_SUB_IMM);
   assign is_sub     = is_sub_acc | is_sub_mem | is_sub_imm;

   assign inc_val   = mem_rdata + ONE_BYTE;
   assign inc_zero  = (inc_val == ZERO_BYTE);
   assign bit_set   = mem_rdata[bit_sel];
   assign take_skip = (is_inc & inc_zero) | (is_bit & bit_set);
   assign sub_operand = is_sub_imm ? imm_data : mem_rdata;

   sub_unit sub_unit_inst (
      .minuend    (accumulator_ff),
      .subtrahend (sub_operand),
      .diff       (sub_diff),
      .flags      (sub_flags)
   );

   // accumulator source: inc result or subtract difference
   assign nxt_accumulator = is_inc ? inc_val
                          : (is_sub_acc | is_sub_imm) ? sub_diff
                          : accumulator_ff;
   // only subtracts touch flags
   assign nxt_flags = is_sub ? sub_flags : flags_ff;

   // a taken skip always buys exactly one dummy slot
   always_comb
   begin
      unique case (state_ff)
         ST_IDLE:  nxt_state = take_skip ? ST_DUMMY : ST_IDLE;
         ST_DUMMY: nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         accumulator_ff <= ACC_RST;
         flags_ff       <= FLAGS_RST;
         mem_we_ff      <= 1'b0;
         mem_wdata_ff   <= ZERO_BYTE;
         skip_ff        <= 1'b0;
         state_ff       <= ST_IDLE;
      end
      else
      begin
         accumulator_ff <= nxt_accumulator;
         flags_ff       <= nxt_flags;
         mem_we_ff      <= is_sub_mem;
         mem_wdata_ff   <= is_sub_mem ? sub_diff : mem_wdata_ff;
         skip_ff        <= take_skip;
         state_ff       <= nxt_state;
      end
   end

   assign accumulator    = accumulator_ff;
   assign carry_flag     = flags_ff[FLAG_C];
   assign aux_carry_flag = flags_ff[FLAG_AC];
   assign zero_flag      = flags_ff[FLAG_Z];
   assign overflow_flag  = flags_ff[FLAG_OV];
   assign mem_we         = mem_we_ff;
   assign mem_wdata      = mem_wdata_ff;
   assign skip_next      = skip_ff;
   assign dummy_slot     = (state_ff == ST_DUMMY);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_inc_issue;
      op_valid && op_ready && op_code == OP_INC_SKIP_ACC;
   endsequence
   sequence s_sub_issue;
      op_valid && op_ready && (op_code == OP_SUB_ACC || op_code == OP_SUB_MEM
                               || op_code == OP_SUB_IMM);
   endsequence

   sequence s_bit_issue;
      op_valid && op_ready && op_code == OP_SKIP_BIT_NZ;
   endsequence
   sequence s_subtract_into_memory_issue;
      op_valid && op_ready && op_code == OP_SUB_MEM;
   endsequence
   // taken skip: one dead slot, then ready again
   sequence s_dead_slot;
      dummy_slot && !op_ready;
   endsequence
   sequence s_ready_again;
      op_ready && !dummy_slot;
   endsequence

   a_inc_acc_value: assert property (
      s_inc_issue |=> accumulator == $past(mem_rdata) + ONE_BYTE && !mem_we)
      else $error("inc-skip accumulator wrong or memory written");
   a_inc_skip_zero: assert property (
      s_inc_issue |=> skip_next == (accumulator == ZERO_BYTE))
      else $error("inc-skip skip decision wrong");
   a_skip_two_cyc: assert property (
      skip_next |-> s_dead_slot ##1 s_ready_again)
      else $error("skip did not take exactly two cycles");
   a_bit_skip_test: assert property (
      op_valid && op_ready && op_code == OP_SKIP_BIT_NZ
      |=> skip_next == $past(mem_rdata[bit_sel]))
      else $error("bit-skip decision wrong");
   a_sub_acc_value: assert property (
      op_valid && op_ready && op_code == OP_SUB_ACC
      |=> accumulator == $past(accumulator) - $past(mem_rdata))
      else $error("subtract into accumulator wrong");
   a_sub_mem_write: assert property (
      op_valid && op_ready && op_code == OP_SUB_MEM
      |=> mem_we && mem_wdata == $past(accumulator) - $past(mem_rdata)
          && $stable(accumulator))
      else $error("subtract into memory wrong");
   a_sub_imm_value: assert property (
      op_valid && op_ready && op_code == OP_SUB_IMM
      |=> accumulator == $past(accumulator) - $past(imm_data))
      else $error("subtract immediate wrong");
   a_sub_carry_sign: assert property (
      s_sub_issue |=> carry_flag == ($past(accumulator) >= ($past(op_code) == OP_SUB_IMM
                                    ? $past(imm_data) : $past(mem_rdata))))
      else $error("carry does not reflect borrow");
   a_skip_flags_keep: assert property (
      op_valid && op_ready && (op_code == OP_INC_SKIP_ACC || op_code == OP_SKIP_BIT_NZ)
      |=> $stable({carry_flag, aux_carry_flag, zero_flag, overflow_flag}))
      else $error("skip instruction changed flags");
   a_sub_zero_flag: assert property (
      op_valid && op_ready && op_code == OP_SUB_ACC
      |=> zero_flag == (accumulator == ZERO_BYTE))
      else $error("zero flag wrong after subtract");
   // flag, side-effect and bit-skip dead-slot guards
   a_sub_aux_flag: assert property (
      s_sub_issue |=> aux_carry_flag == ($past(accumulator[3:0])
                                         >= ($past(op_code) == OP_SUB_IMM
                                             ? $past(imm_data[3:0]) : $past(mem_rdata[3:0]))))
      else $error("aux carry does not reflect a low nibble borrow");
   a_sub_ov_flag: assert property (
      op_valid && op_ready && op_code == OP_SUB_ACC
      |=> overflow_flag == ($past(accumulator[SIGN_BIT]) != $past(mem_rdata[SIGN_BIT])
                            && accumulator[SIGN_BIT] != $past(accumulator[SIGN_BIT])))
      else $error("overflow flag wrong after subtract");
   a_subtract_into_memory_zero_flag: assert property (
      s_subtract_into_memory_issue |=> zero_flag == (mem_wdata == ZERO_BYTE))
      else $error("zero flag wrong after subtract into memory");
   a_subi_zero_flag: assert property (
      op_valid && op_ready && op_code == OP_SUB_IMM
      |=> zero_flag == (accumulator == ZERO_BYTE))
      else $error("zero flag wrong after subtract immediate");
   a_dummy_no_effect: assert property (
      dummy_slot |=> $stable(accumulator) && !mem_we && !skip_next
                     && $stable({carry_flag, aux_carry_flag, zero_flag, overflow_flag}))
      else $error("dummy slot had an effect");
   a_mem_untouched: assert property (
      !(op_valid && op_ready && op_code == OP_SUB_MEM)
      |=> !mem_we && $stable(mem_wdata))
      else $error("memory written by a non-subtract instruction");
   a_bit_dead_slot: assert property (
      s_bit_issue ##0 mem_rdata[bit_sel] |=> s_dead_slot ##1 s_ready_again)
      else $error("taken bit-skip did not hold a dummy slot");
endmodule // skip_subtract_exec
`default_nettype wire

// file: inc/skip_sub_pkg.sv
// shared constants for the skip and subtract execution block
package skip_sub_pkg;
   localparam int DATA_W = 8;
   localparam int BIT_SEL_W = 3;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam int SKIP_CYCLES = 2;
   localparam int AUX_BIT = 4;
   localparam int SIGN_BIT = 7;
   // status flag positions in flags_ff
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_INC_SKIP_ACC = 3'b001,
      OP_SKIP_BIT_NZ = 3'b010,
      OP_SUB_ACC = 3'b011,
      OP_SUB_MEM = 3'b100,
      OP_SUB_IMM = 3'b101
   } op_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DUMMY = 2'b01
   } exec_state_e;
endpackage

// file: hw/sub_unit.sv
// 8-bit subtractor producing difference and status flags
`timescale 1ns/100ps
`default_nettype none
module sub_unit
   import skip_sub_pkg::*;
(
   input  wire logic [7:0] minuend,     // accumulator value
   input  wire logic [7:0] subtrahend,  // memory byte or immediate
   output logic      [7:0] diff,        // difference
   output logic      [3:0] flags        // ov, z, ac, c
);
   wire logic [8:0] full_sub;
   wire logic [4:0] low_sub;
   assign full_sub = {1'b0, minuend} - {1'b0, subtrahend};
   assign low_sub  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
   assign diff = full_sub[7:0];
   // borrow means negative: carry cleared
   assign flags[FLAG_C]  = ~full_sub[8];
   assign flags[FLAG_AC] = ~low_sub[AUX_BIT];
   assign flags[FLAG_Z]  = (full_sub[7:0] == ZERO_BYTE);
   assign flags[FLAG_OV] = (minuend[SIGN_BIT] != subtrahend[SIGN_BIT])
                         & (full_sub[SIGN_BIT] != minuend[SIGN_BIT]);
endmodule // sub_unit
`default_nettype wire

// file: test/test_skip_subtract_exec.sv
// self-checking bench for the skip and subtract execution block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_skip_subtract_exec
   import skip_sub_pkg::*;
;
   logic       sys_clk, nrst, op_valid, op_ready, mem_we, skip_next, dummy_slot;
   logic [2:0] op_code, bit_sel;
   logic [7:0] mem_rdata, imm_data, accumulator, mem_wdata;
   logic       carry_flag, aux_carry_flag, zero_flag, overflow_flag;
   int         checked, mismatches, cycles;
   wire  [3:0] flg = {overflow_flag, zero_flag, aux_carry_flag, carry_flag};

   skip_subtract_exec skip_subtract_exec_inst (.sys_clk(sys_clk), .nrst(nrst),
      .op_valid(op_valid), .op_code(op_code), .mem_rdata(mem_rdata), .imm_data(imm_data),
      .bit_sel(bit_sel), .op_ready(op_ready), .accumulator(accumulator),
      .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag), .zero_flag(zero_flag),
      .overflow_flag(overflow_flag), .mem_we(mem_we), .mem_wdata(mem_wdata),
      .skip_next(skip_next), .dummy_slot(dummy_slot));

   // {ov, z, ac, c} of a minus b
   function automatic logic [3:0] exp_flags(input logic [7:0] a, b);
      logic [7:0] d;
      d = a - b;
      return {(a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
   endfunction

   task automatic issue(input logic [2:0] op, input logic [7:0] m, im, input logic [2:0] b);
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= op;
      mem_rdata <= m;
      imm_data <= im;
      bit_sel <= b;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      #1;
   endtask

   task automatic t_sub;
      logic [15:0] tbl [4] = '{16'h0507, 16'h0505, 16'h8001, 16'h1001};
      logic [7:0]  a, m;
      for (int k = 0; k < 4; k++)
      begin
         for (int op = 3; op < 6; op++)
         begin
            a = tbl[k][15:8];
            m = tbl[k][7:0];
            issue(3'h1, a - 8'h01, 8'h00, 3'h0);
            issue(op[2:0], (op == 5) ? ~m : m, (op == 5) ? m : ~m, 3'h0);
            if (op == 4)
            begin
               `CHK("wdata", a - m, mem_wdata)
               `CHK("we", 1'b1, mem_we)
               `CHK("acc kept", a, accumulator)
            end
            else
               `CHK("acc", a - m, accumulator)
            `CHK("flags", exp_flags(a, m), flg)
         end
      end
   endtask

   task automatic t_inc;
      logic [3:0] f;
      f = flg;
      issue(3'h1, 8'hFF, 8'h00, 3'h0);
      `CHK("acc wrap", 8'h00, accumulator)
      `CHK("skip", 3'b110, {skip_next, dummy_slot, op_ready})
      `CHK("no write", 1'b0, mem_we)
      `CHK("flags kept", f, flg)
      @(posedge sys_clk);
      #1;
      `CHK("after dummy", 3'b001, {skip_next, dummy_slot, op_ready})
      issue(3'h1, 8'h05, 8'h00, 3'h0);
      `CHK("acc inc", 8'h06, accumulator)
      `CHK("no skip", 1'b0, skip_next)
   endtask

   task automatic t_bit;
      logic [3:0] f;
      f = flg;
      for (int i = 0; i < 8; i++)
      begin
         issue(3'h2, 8'h01 << i, 8'h00, i[2:0]);
         `CHK("bit set", 1'b1, skip_next)
         `CHK("bit slot", 2'b10, {dummy_slot, op_ready})
         issue(3'h2, ~(8'h01 << i), 8'h00, i[2:0]);
         `CHK("bit clear", 1'b0, skip_next)
         `CHK("bit no slot", 2'b01, {dummy_slot, op_ready})
      end
      `CHK("bit flags", f, flg)
   endtask

   task automatic print_verdict;
      if (mismatches == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         mismatches++;
         print_verdict;
      end
   end

   initial
   begin
      nrst = 1'b0;
      op_valid = 1'b0;
      op_code = 3'h0;
      mem_rdata = 8'h00;
      imm_data = 8'h00;
      bit_sel = 3'h0;
      repeat (16) @(posedge sys_clk);
      `CHK("reset acc", 8'h00, accumulator)
      nrst <= 1'b1;
      t_sub;
      t_inc;
      t_bit;
      print_verdict;
   end
endmodule // test_skip_subtract_exec
`default_nettype wire
